// File: core/sss_defs.svh
`ifndef SSS_DEFS_SVH
`define SSS_DEFS_SVH
// ==========================================
// instruction codes
`define SSS_CMD_READ_CONFIG  8'h05
`define SSS_CMD_WRITE_CONFIG 8'h01
// ==========================================
// configuration/status layout
`define SSS_MODE_HI          7
`define SSS_MODE_LO          6
`define SSS_PAUSE_DIS_BIT    0
`define SSS_FIXED_ONE_BIT    1
`define SSS_CFG_WMASK        8'hc1
`define SSS_CFG_FIXED        8'h02
`define SSS_CFG_RESET        8'h02
`define SSS_MODE_BYTE        2'h0
`define SSS_MODE_PAGE        2'h2
`define SSS_MODE_SEQ         2'h1
`define SSS_MODE_RSVD        2'h3
`define SSS_FIFO_DEPTH       32
`endif

// File: core/sss_pkg.sv
package sss_pkg;
    typedef enum logic [4:0] {
        SSS_IDLE  = 5'h01,
        SSS_CMD   = 5'h02,
        SSS_RDCFG = 5'h04,
        SSS_WRCFG = 5'h08,
        SSS_OTHER = 5'h10
    } sss_state_type;
    typedef enum logic [1:0] {
        SSS_XFER_BYTE = 2'h0,
        SSS_XFER_SEQ  = 2'h1,
        SSS_XFER_PAGE = 2'h2,
        SSS_XFER_RSVD = 2'h3
    } sss_mode_type;
endpackage

// File: core/sss_fifo.sv
`include "sss_defs.svh"
module sss_fifo
    import sss_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = `SSS_FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    logic             wr;
    logic             rd;
    assign in_ready  = (cnt_r < (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign wr        = in_valid && in_ready;
    assign rd        = out_valid && out_ready;
    always_ff @(posedge clk) begin
        if (wr) begin
            mem_r[wp_r] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (wr) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (rd) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
        end
    end
endmodule // sss_fifo

// File: core/sss_spi_slave.sv
`include "sss_defs.svh"
module sss_spi_slave
    import sss_pkg::*;
#(
    parameter int FIFO_DEPTH = `SSS_FIFO_DEPTH
) (
    input  wire logic       CLK_SYS,
    input  wire logic       RST_N,
    input  wire logic       SCK,
    input  wire logic       CS_N,
    input  wire logic       SI,
    input  wire logic       PAUSE_N,
    output logic            SO,
    output logic            SO_OE_N,
    output logic            CMD_VALID,
    input  wire logic       CMD_READY,
    output logic      [7:0] CMD_BYTE,
    output logic      [1:0] XFER_MODE,
    output logic      [7:0] CONFIG
);
    // ==========================================
    // synchronisers
    logic [1:0] sck_s_r;
    logic [1:0] cs_s_r;
    logic [1:0] si_s_r;
    logic [1:0] pause_s_r;
    logic       sck_d_r;
    logic       cs_d_r;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            sck_s_r   <= 2'h0;
            cs_s_r    <= 2'h3;
            si_s_r    <= 2'h0;
            pause_s_r <= 2'h3;
            sck_d_r   <= 1'b0;
            cs_d_r    <= 1'b1;
        end else begin
            sck_s_r   <= {sck_s_r[0], SCK};
            cs_s_r    <= {cs_s_r[0], CS_N};
            si_s_r    <= {si_s_r[0], SI};
            pause_s_r <= {pause_s_r[0], PAUSE_N};
            sck_d_r   <= sck_s_r[1];
            cs_d_r    <= cs_s_r[1];
        end
    end
    logic sck;
    logic cs_n;
    logic pause_n;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    assign sck      = sck_s_r[1];
    assign cs_n     = cs_s_r[1];
    assign pause_n  = pause_s_r[1];
    assign sck_rise = sck && !sck_d_r;
    assign sck_fall = !sck && sck_d_r;
    assign cs_fall  = !cs_n && cs_d_r;
    // ==========================================
    // configuration register
    logic [7:0] cfg_r;
    logic       pause_en;
    assign pause_en = !cfg_r[`SSS_PAUSE_DIS_BIT];
    assign CONFIG    = cfg_r;
    assign XFER_MODE = cfg_r[`SSS_MODE_HI:`SSS_MODE_LO];
    // ==========================================
    // pause tracking
    logic paused_r;
    logic active_r;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            paused_r <= 1'b0;
        end else if (cs_n || !pause_en) begin
            paused_r <= 1'b0;
        end else if (!paused_r && !pause_n && active_r && (!sck || sck_fall)) begin
            paused_r <= 1'b1;
        end else if (paused_r && pause_n && !sck) begin
            paused_r <= 1'b0;
        end
    end
    logic shift_en;
    assign shift_en = !cs_n && !paused_r && active_r;
    // ==========================================
    // shifter and sequencer
    sss_state_type state_r;
    logic [7:0]    sh_in_r;
    logic [2:0]    bit_r;
    logic [7:0]    sh_out_r;
    logic          so_r;
    logic [7:0]    in_nxt;
    logic          fifo_ready;
    assign in_nxt = {sh_in_r[6:0], si_s_r[1]};
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            active_r <= 1'b0;
        end else if (cs_n) begin
            active_r <= 1'b0;
        end else if (cs_fall) begin
            active_r <= 1'b1;
        end
    end
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            state_r  <= SSS_IDLE;
            sh_in_r  <= 8'h00;
            bit_r    <= 3'h0;
            sh_out_r <= 8'h00;
            so_r     <= 1'b0;
            cfg_r    <= `SSS_CFG_RESET;
        end else if (cs_n) begin
            state_r <= SSS_IDLE;
            bit_r   <= 3'h0;
        end else if (cs_fall) begin
            state_r <= SSS_CMD;
            bit_r   <= 3'h0;
        end else if (shift_en && sck_rise) begin
            sh_in_r <= in_nxt;
            bit_r   <= bit_r + 3'h1;
            unique case (state_r)
                SSS_CMD: begin
                    if (bit_r == 3'h7) begin
                        if (in_nxt == `SSS_CMD_READ_CONFIG) begin
                            state_r  <= SSS_RDCFG;
                            sh_out_r <= cfg_r;
                        end else if (in_nxt == `SSS_CMD_WRITE_CONFIG) begin
                            state_r <= SSS_WRCFG;
                        end else begin
                            state_r <= SSS_OTHER;
                        end
                    end
                end
                SSS_WRCFG: begin
                    if (bit_r == 3'h7) begin
                        cfg_r   <= (in_nxt & `SSS_CFG_WMASK) | `SSS_CFG_FIXED;
                        state_r <= SSS_OTHER;
                    end
                end
                SSS_RDCFG: begin
                    if (bit_r == 3'h7) begin
                        sh_out_r <= cfg_r;
                    end
                end
                SSS_IDLE, SSS_OTHER: begin
                end
            endcase
        end else if (shift_en && sck_fall && state_r == SSS_RDCFG) begin
            so_r     <= sh_out_r[7];
            sh_out_r <= {sh_out_r[6:0], 1'b0};
        end
    end
    assign SO      = so_r;
    assign SO_OE_N = !(state_r == SSS_RDCFG && !cs_n && pause_n && !paused_r);
    // ==========================================
    // received byte stream for the array side
    logic byte_done;
    assign byte_done = shift_en && sck_rise && bit_r == 3'h7 && state_r == SSS_OTHER;
    sss_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLK_SYS),
        .rst_n     (RST_N),
        .in_valid  (byte_done),
        .in_ready  (fifo_ready),
        .in_data   (in_nxt),
        .out_valid (CMD_VALID),
        .out_ready (CMD_READY),
        .out_data  (CMD_BYTE)
    );
    // ==========================================
    // checks
    cfg_fixed_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        cfg_r[5:1] == 5'h01) else $error("fixed config bits wrong");
    oe_cs_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        cs_n |-> SO_OE_N) else $error("output driven while deselected");
    oe_pause_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !pause_n |-> SO_OE_N) else $error("output driven while pause low");
    paused_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        paused_r && !cs_n |=> $stable(bit_r)) else $error("bit moved while paused");
    resume_low_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $fell(paused_r) && !cs_n |-> $past(!sck_s_r[1])) else $error("resume with clock high");
    pause_dis_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        cfg_r[0] |=> !paused_r) else $error("paused while disabled");
    wr_cfg_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        state_r == SSS_WRCFG && shift_en && sck_rise && bit_r == 3'h7
        |=> cfg_r == (($past(in_nxt) & 8'hc1) | 8'h02)) else $error("config write lost");
    idle_cs_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !active_r |-> $stable(sh_in_r) or $past(!active_r) == 1'b0) else $error("shift idle");
    rd_cover_c: cover property (@(posedge CLK_SYS) state_r == SSS_RDCFG && !SO_OE_N);
    wr_cover_c: cover property (@(posedge CLK_SYS) $changed(cfg_r));
    pause_cover_c: cover property (@(posedge CLK_SYS) $fell(paused_r) && !cs_n);
endmodule // sss_spi_slave

// File: test/sss_host_model.sv
// ==========================================
// host side of the serial link
module sss_host_model (
    output logic      SCK,
    output logic      CS_N,
    output logic      SI,
    output logic      PAUSE_N,
    input  wire logic SO,
    input  wire logic SO_OE_N
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam realtime HALF = 62.5;
    logic [7:0] rx_byte = 8'h00;
    logic       oe_seen = 1'b1;
    event       rx_done;
    initial begin
        SCK = 1'b0;
        CS_N = 1'b1;
        SI = 1'b0;
        PAUSE_N = 1'b1;
    end
    // ==========================================
    // select and release
    task automatic sel(input logic on);
        #HALF CS_N = ~on;
        if (!on) SI = ~SI;
        #HALF;
    endtask
    // ==========================================
    // one byte, optional pause before bit pause_at
    task automatic xfer(input logic [7:0] tx, input int pause_at, input bit report);
        for (int i = 7; i >= 0; i--) begin
            SI = tx[i];
            if (i == pause_at) begin
                PAUSE_N = 1'b0;
                #HALF oe_seen = SO_OE_N;
                SCK = 1'b1;
                SI = ~SI;
                #HALF PAUSE_N = 1'b1;
                #HALF oe_seen = oe_seen & SO_OE_N;
                PAUSE_N = 1'b0;
                SCK = 1'b0;
                SI = ~SI;
                #HALF PAUSE_N = 1'b1;
            end
            #HALF SCK = 1'b1;
            rx_byte[i] = SO;
            #HALF SCK = 1'b0;
        end
        if (report) ->rx_done;
    endtask
endmodule // sss_host_model

// File: test/testbench.sv
`include "sss_defs.svh"
module testbench import sss_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic       CLK_SYS = 1'b0;
    logic       RST_N = 1'b0;
    logic       CMD_READY = 1'b0;
    wire        SCK, CS_N, SI, PAUSE_N, SO, SO_OE_N, CMD_VALID;
    wire  [7:0] CMD_BYTE, CONFIG;
    wire  [1:0] XFER_MODE;
    logic [7:0] exp_q[$];
    logic [7:0] d;
    int         n_mismatch = 0;
    int         checked = 0;
    int         seed = 32'h7ad168cb;
    always #4 CLK_SYS = ~CLK_SYS;
    sss_spi_slave sss_spi_slave_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
        .SCK(SCK), .CS_N(CS_N), .SI(SI), .PAUSE_N(PAUSE_N), .SO(SO), .SO_OE_N(SO_OE_N),
        .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_BYTE(CMD_BYTE),
        .XFER_MODE(XFER_MODE), .CONFIG(CONFIG));
    sss_host_model sss_host_model_i (.SCK(SCK), .CS_N(CS_N), .SI(SI), .PAUSE_N(PAUSE_N),
        .SO(SO), .SO_OE_N(SO_OE_N));
    // ==========================================
    // compare and finish
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ==========================================
    // result watchers
    always @(sss_host_model_i.rx_done) begin
        check(sss_host_model_i.rx_byte, exp_q.pop_front());
    end
    always @(posedge CLK_SYS) begin
        if (CMD_VALID === 1'b1 && CMD_READY) check(CMD_BYTE, exp_q.pop_front());
    end
    // ==========================================
    // config access
    task automatic rd_cfg(input logic [7:0] e, input int p);
        exp_q.push_back(e);
        sss_host_model_i.sel(1'b1);
        sss_host_model_i.xfer(`SSS_CMD_READ_CONFIG, 8, 1'b0);
        sss_host_model_i.xfer(8'h00, p, 1'b1);
        sss_host_model_i.sel(1'b0);
        check(SO_OE_N, 1'b1);
        if (p < 8) check(sss_host_model_i.oe_seen, 1'b1);
    endtask
    task automatic cfg_rw(input logic [7:0] w, input int p);
        logic [7:0] e;
        e = (w & `SSS_CFG_WMASK) | `SSS_CFG_FIXED;
        sss_host_model_i.sel(1'b1);
        sss_host_model_i.xfer(`SSS_CMD_WRITE_CONFIG, 8, 1'b0);
        sss_host_model_i.xfer(w, p, 1'b0);
        sss_host_model_i.sel(1'b0);
        check(CONFIG, e);
        check(XFER_MODE, e[7:6]);
        rd_cfg(e, p);
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (8) @(posedge CLK_SYS);
        #1 RST_N = 1'b1;
        check(CONFIG, `SSS_CFG_RESET);
        check(SO_OE_N, 1'b1);
        sss_host_model_i.xfer(`SSS_CMD_WRITE_CONFIG, 8, 1'b0);
        sss_host_model_i.xfer(8'hc1, 8, 1'b0);
        check(CONFIG, `SSS_CFG_RESET);
        rd_cfg(`SSS_CFG_RESET, 8);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            cfg_rw({2'(m), 5'h00, (m < 3) && 1'($random(seed))}, 8);
        end
        $display("test modes done");
        cfg_rw(8'h40, 2);
        $display("test pause done");
        sss_host_model_i.sel(1'b1);
        sss_host_model_i.xfer(8'h02, 8, 1'b0);
        for (int i = 0; i < 33; i++) begin
            d = 8'($random(seed));
            if (i < 32) exp_q.push_back(d);
            sss_host_model_i.xfer(d, 8, 1'b0);
        end
        sss_host_model_i.sel(1'b0);
        check(CMD_VALID, 1'b1);
        for (int i = 0; i < 2000 && exp_q.size() > 0; i++) begin
            @(posedge CLK_SYS);
            #1 CMD_READY = 1'($random(seed));
        end
        CMD_READY = 1'b0;
        repeat (2) @(posedge CLK_SYS);
        check(8'(exp_q.size()), 8'h00);
        check(CMD_VALID, 1'b0);
        $display("test buffer done");
        end_sim();
    end
    initial begin
        #300us;
        n_mismatch++;
        end_sim();
    end
endmodule // testbench
